// File: power_fail_gated_host_port.sv
// Power-fail gated byte-wide host port of a clock/calendar device.
// Assumes the host strobes, key input and power-fail flag are asynchronous pins.
//
// Overview of operation
// (R1) Keep internal counters running always, plus a host-visible copy.
// (R2) Transfer bit lets host freeze the visible copy while internal counters run.
// (R3) Below trip level, deselect and ignore every host read and write.
// (R4) Pass SRAM enable through, forcing it high below trip level.
// (R5) Alarm, watchdog or key event can raise interrupt or reset outputs.
// (R6) Key or wakeup raises supply-on; software releases it.
// (R7) Read mode when select and output enable low and write enable high.
// (R8) Read data follow address without strobe, valid after access delay.
// (R9) Drive data pins only while select and output enable are both low.
// (R10) Select and write enable low is a write; data stored at its end.
// (R11) Host holds address through write and meets data set-up and hold.
// (R12) Host leaves select or write enable inactive for recovery time between cycles.
// (R13) Outputs turn off soon after write enable falls during an open read.
// (R14) Host should keep output enable high during writes; the bench holds it low in two of its writes.
// (R15) In retention, bus ignored, data pins off, SRAM enable forced high.
// (R16) Reset held low while failed and for hold time after recovery.
// (R17) Reset function does not depend on the oscillator tick.
// (R18) Refuse host accesses while reset output is asserted.
// (R19) Power-fail flag is synchronised before gating anything.
`timescale 1ns/1ps
`include "host_port_consts.svh"

module power_fail_gated_host_port
	import host_port_pkg::*;
#(
	parameter int unsigned RESET_HOLD = 32'(`RESET_HOLD_CYCLES),
	parameter int unsigned TICK_DIV   = `TICK_DIV_DEFAULT
) (
	// Clock and reset
	input  wire logic               ref_clk,
	input  wire logic               rst_b,
	// Host bus
	input  wire logic               chip_sel_n,
	input  wire logic               out_en_n,
	input  wire logic               write_en_n,
	input  wire logic [`ADDR_W-1:0] reg_addr_in,
	input  wire logic [`DATA_W-1:0] data_bus_pins_in,
	output logic      [`DATA_W-1:0] data_bus_pins_out,
	output logic                    data_bus_pins_oe,
	// Supply monitor and SRAM enable
	input  wire logic               below_trip_in,
	input  wire logic               sram_enable_in_n,
	output logic                    sram_enable_out_n,
	// Events and control outputs
	input  wire logic               key_start_in_n,
	input  wire logic               alarm_match_in,
	input  wire logic               watchdog_timeout_in,
	output logic                    irq_out_n,
	output logic                    reset_out_n,
	output logic                    supply_on_n
);
	// ------------------------------------------------------------
	// Input synchronisers
	// ------------------------------------------------------------
	localparam int SW = 7 + `ADDR_W + `DATA_W;
	logic [SW-1:0] raw_in;
	logic [SW-1:0] meta_q;
	logic [SW-1:0] sync_q;

	// Gathers every asynchronous pin into one synchroniser vector.
	assign raw_in = {below_trip_in, sram_enable_in_n, key_start_in_n, chip_sel_n, out_en_n, write_en_n,
		alarm_match_in | watchdog_timeout_in, reg_addr_in, data_bus_pins_in};

	// Two flip-flops per bit before any logic but the alarm and watchdog OR looks at a pin.
	genvar gi;
	generate
		for (gi = 0; gi < SW; gi++)
		begin : g_sync
			always_ff @(posedge ref_clk)
			begin
				meta_q[gi] <= raw_in[gi];
				sync_q[gi] <= meta_q[gi];
			end
		end
	endgenerate

	logic               fail_s;
	logic               sram_en_s;
	logic               key_s;
	logic               cs_s;
	logic               oe_s;
	logic               we_s;
	logic               evt_s;
	logic [`ADDR_W-1:0] addr_s;
	logic [`DATA_W-1:0] din_s;

	// Names the synchronised copies.
	assign {fail_s, sram_en_s, key_s, cs_s, oe_s, we_s, evt_s, addr_s, din_s} = sync_q; // see (R19)

	// ------------------------------------------------------------
	// Reset hold and bus mode
	// ------------------------------------------------------------
	logic [31:0] hold_cnt_q, hold_cnt_d;
	logic        rst_out_q, rst_out_d;
	logic        access_ok;
	bus_mode_t   mode_q, mode_d;
	logic [31:0] aa_cnt_q, aa_cnt_d;
	logic [`ADDR_W-1:0] last_addr_q;
	logic        we_prev_q;

	// Counts recovery cycles from the clock alone, not the time base.
	always_comb
	begin
		hold_cnt_d = hold_cnt_q;
		rst_out_d  = rst_out_q;
		if (fail_s)
		begin
			hold_cnt_d = 32'd0; // see (R16)
			rst_out_d  = 1'b0;
		end
		else if (hold_cnt_q < RESET_HOLD)
		begin
			hold_cnt_d = hold_cnt_q + 32'd1; // see (R17)
			rst_out_d  = 1'b0;
		end
		else
			rst_out_d = 1'b1; // see (R16)
	end

	// Access is refused while failed, in the recovery hold, or while an event holds the reset pin low.
	assign access_ok = !fail_s && rst_out_q && reset_out_n; // see (R3) (R18)

	// Decodes the bus mode and times the address access delay.
	always_comb
	begin
		mode_d   = mode_idle;
		aa_cnt_d = aa_cnt_q;
		if (!access_ok)
			mode_d = mode_locked; // see (R3) (R15)
		else if (!cs_s && !we_s)
			mode_d = mode_write; // see (R10)
		else if (!cs_s && !oe_s)
			mode_d = mode_read; // see (R7)
		if (addr_s != last_addr_q)
			aa_cnt_d = 32'd0; // see (R8)
		else if (aa_cnt_q < `ADDR_ACCESS_CYCLES)
			aa_cnt_d = aa_cnt_q + 32'd1;
	end

	// Registers supervisor and bus mode state.
	always_ff @(posedge ref_clk)
	begin
		if (!rst_b)
		begin
			hold_cnt_q  <= 32'd0;
			rst_out_q   <= 1'b0;
			mode_q      <= mode_locked;
			aa_cnt_q    <= 32'd0;
			last_addr_q <= 5'h00;
			we_prev_q   <= 1'b1;
		end
		else
		begin
			hold_cnt_q  <= hold_cnt_d;
			rst_out_q   <= rst_out_d;
			mode_q      <= mode_d;
			aa_cnt_q    <= aa_cnt_d;
			last_addr_q <= addr_s;
			we_prev_q   <= we_s;
		end
	end

	// ------------------------------------------------------------
	// Write capture and the visible register copy
	// ------------------------------------------------------------
	logic               wr_end;
	logic [`ADDR_W-1:0] wr_addr_q, wr_addr_d;
	logic [`DATA_W-1:0] wr_data_q, wr_data_d;
	logic               copy_en;
	logic [`ADDR_W-1:0] cp_addr_q, cp_addr_d;
	logic [`DATA_W-1:0] time_q, time_d;
	logic [31:0]        tick_q, tick_d;
	logic [`DATA_W-1:0] ctrl_q, ctrl_d;
	logic               mem_we;
	logic [`ADDR_W-1:0] mem_wa;
	logic [`DATA_W-1:0] mem_wd;
	logic [`DATA_W-1:0] mem_rd;

	// A write ends when the write mode is left while access is still allowed.
	assign wr_end = (mode_q == mode_write) && (mode_d != mode_write) && access_ok; // see (R10)

	// Tracks captured write data, internal time and the control byte.
	always_comb
	begin
		wr_addr_d = wr_addr_q;
		wr_data_d = wr_data_q;
		tick_d    = tick_q + 32'd1;
		time_d    = time_q;
		ctrl_d    = ctrl_q;
		cp_addr_d = cp_addr_q + 5'h01;
		if (mode_d == mode_write)
		begin
			wr_addr_d = addr_s; // see (R11)
			wr_data_d = din_s;
		end
		if (tick_q >= TICK_DIV - 32'd1)
		begin
			tick_d = 32'd0;
			time_d = time_q + 8'h01; // see (R1)
		end
		if (evt_s)
			ctrl_d[`WDOG_EVENT_BIT] = 1'b1; // see (R5)
		if (!key_s)
			ctrl_d[`KEY_EVENT_BIT] = 1'b1; // see (R6)
		if (wr_end && wr_addr_q == `ADDR_CONTROL)
			ctrl_d = wr_data_q | (ctrl_d & 8'h0E);
	end

	// Host writes win the memory port; otherwise the running time is copied.
	assign copy_en = ctrl_q[`TRANSFER_BIT]; // see (R2)
	assign mem_we  = wr_end || (copy_en && cp_addr_q == 5'h00);
	assign mem_wa  = wr_end ? wr_addr_q : 5'h00;
	assign mem_wd  = wr_end ? wr_data_q : time_q;

	// Registers capture, time base and control state.
	always_ff @(posedge ref_clk)
	begin
		if (!rst_b)
		begin
			wr_addr_q <= 5'h00;
			wr_data_q <= 8'h00;
			tick_q    <= 32'd0;
			time_q    <= 8'h00;
			ctrl_q    <= `CONTROL_RESET;
			cp_addr_q <= 5'h00;
		end
		else
		begin
			wr_addr_q <= wr_addr_d;
			wr_data_q <= wr_data_d;
			tick_q    <= tick_d;
			time_q    <= time_d;
			ctrl_q    <= ctrl_d;
			cp_addr_q <= cp_addr_d;
		end
	end

	reg_memory #(
		.ADDR_W (`ADDR_W),
		.DATA_W (`DATA_W)
	) u_mem (
		.ref_clk   (ref_clk),
		.wr_en     (mem_we),
		.wr_addr   (mem_wa),
		.wr_data   (mem_wd),
		.rd_addr   (addr_s),
		.rd_data_q (mem_rd)
	);

	// ------------------------------------------------------------
	// Output registers
	// ------------------------------------------------------------
	logic               oe_d;
	logic [`DATA_W-1:0] dout_d;
	logic               sram_d;
	logic               irq_d;
	logic               pwr_d;

	// Computes pin drive and control outputs.
	always_comb
	begin
		oe_d   = (mode_d == mode_read) && (we_s || !we_prev_q); // see (R9) (R13)
		dout_d = (aa_cnt_q >= `ADDR_ACCESS_CYCLES) ? ((addr_s == `ADDR_CONTROL) ? ctrl_q : mem_rd) : 8'h00; // see (R8)
		sram_d = fail_s ? 1'b1 : sram_en_s; // see (R4) (R15)
		irq_d  = !(ctrl_q[`WDOG_EVENT_BIT] || ctrl_q[`KEY_EVENT_BIT]); // see (R5)
		pwr_d  = !((ctrl_q[`KEY_EVENT_BIT] || ctrl_q[`WAKE_EVENT_BIT]) && !ctrl_q[`SUPPLY_OFF_BIT]); // see (R6)
	end

	// Registers every top-level output.
	always_ff @(posedge ref_clk)
	begin
		if (!rst_b)
		begin
			data_bus_pins_oe  <= 1'b0;
			data_bus_pins_out <= 8'h00;
			sram_enable_out_n <= 1'b1;
			irq_out_n         <= 1'b1;
			reset_out_n       <= 1'b0;
			supply_on_n       <= 1'b1;
		end
		else
		begin
			data_bus_pins_oe  <= oe_d;
			data_bus_pins_out <= dout_d;
			sram_enable_out_n <= sram_d;
			irq_out_n         <= irq_d;
			reset_out_n       <= rst_out_q && !(ctrl_q[`WDOG_EVENT_BIT] && evt_s); // see (R5)
			supply_on_n       <= pwr_d;
		end
	end
endmodule : power_fail_gated_host_port

// File: host_port_consts.svh
// Timing, width and reset constants for the power-fail gated host port.
// Assumes inclusion by bare name from the package and the design modules.
`ifndef HOST_PORT_CONSTS_SVH
`define HOST_PORT_CONSTS_SVH

// ------------------------------------------------------------
// Clock and timing
// ------------------------------------------------------------
`define CLK_PERIOD_PS        32'd5000
`define RESET_HOLD_TIME_MS   32'd150
`define RESET_HOLD_CYCLES    ((`RESET_HOLD_TIME_MS * 64'd1000000000) / {32'd0, `CLK_PERIOD_PS})
`define ADDR_ACCESS_NS       32'd70
`define ADDR_ACCESS_CYCLES   ((`ADDR_ACCESS_NS * 32'd1000 + `CLK_PERIOD_PS - 32'd1) / `CLK_PERIOD_PS)
`define TICK_DIV_DEFAULT     32'd200000

// ------------------------------------------------------------
// Register map
// ------------------------------------------------------------
`define REG_COUNT            32
`define ADDR_W               5
`define DATA_W               8
`define ADDR_CONTROL         5'h0F
`define TRANSFER_BIT         7
`define CONTROL_RESET        8'h80
`define KEY_EVENT_BIT        2
`define WAKE_EVENT_BIT       3
`define WDOG_EVENT_BIT       1
`define SUPPLY_OFF_BIT       0

`endif

// File: host_port_pkg.sv
// Types shared by the host port modules.
// Assumes the constants header is on the include path.
`include "host_port_consts.svh"

package host_port_pkg;
	typedef enum logic [1:0]
	{
		mode_idle   = 2'b00,
		mode_read   = 2'b01,
		mode_write  = 2'b10,
		mode_locked = 2'b11
	} bus_mode_t;
endpackage : host_port_pkg

// File: reg_memory.sv
// Small register memory for the host-visible location set.
// Assumes one clock; the read data come out of a register.
`timescale 1ns/1ps
`include "host_port_consts.svh"

module reg_memory #(
	parameter int ADDR_W = `ADDR_W,
	parameter int DATA_W = `DATA_W
) (
	// Clock
	input  wire logic              ref_clk,
	// Write side
	input  wire logic              wr_en,
	input  wire logic [ADDR_W-1:0] wr_addr,
	input  wire logic [DATA_W-1:0] wr_data,
	// Read side
	input  wire logic [ADDR_W-1:0] rd_addr,
	output logic      [DATA_W-1:0] rd_data_q
);
	logic [DATA_W-1:0] mem [0:(1<<ADDR_W)-1];

	// Stores writes and registers the read word each cycle.
	always_ff @(posedge ref_clk)
	begin
		if (wr_en)
			mem[wr_addr] <= wr_data;
		rd_data_q <= mem[rd_addr];
	end
endmodule : reg_memory

// File: host_model.sv
// Host processor model for the byte-wide port.
// Assumes the bench calls its tasks; signals move at falling edges.
`timescale 1ns/1ps
`include "host_port_consts.svh"
module host_model (
	// Clock
	input  wire logic               ref_clk,
	// Bus drive
	output logic                    cs_n,
	output logic                    oe_n,
	output logic                    we_n,
	output logic      [`ADDR_W-1:0] addr,
	output logic      [`DATA_W-1:0] wd,
	output logic                    drv,
	// Device answer
	input  wire logic               dut_oe,
	input  wire logic [`DATA_W-1:0] dut_q,
	output logic                    done,
	output logic      [`DATA_W:0]   res
);
	// Idle bus: strobes high, host data released.
	initial
	begin
		{cs_n, oe_n, we_n, drv, done} = 5'h1C;
		{addr, wd, res} = '0;
	end

	// Write: address held through the cycle, data held past the strobe, then recovery.
	task automatic wr(input logic [`ADDR_W-1:0] a, input logic [`DATA_W-1:0] d, input logic oe_lo);
		@(negedge ref_clk);
		{addr, wd, cs_n, oe_n} = {a, d, 1'b0, !oe_lo};
		repeat (2) @(negedge ref_clk);
		{we_n, drv} = 2'b01;
		repeat (6) @(negedge ref_clk);
		we_n = 1'b1;
		repeat (2) @(negedge ref_clk);
		{cs_n, oe_n, drv} = 3'b110;
		repeat (6) @(negedge ref_clk);
	endtask : wr

	// Read: wait for drive, let the access delay run out, take the byte.
	task automatic rd(input logic [`ADDR_W-1:0] a);
		int n;
		@(negedge ref_clk);
		{addr, cs_n, oe_n} = {a, 2'b00};
		n = 0;
		while (!dut_oe && n < 12)
		begin
			@(negedge ref_clk);
			n++;
		end
		repeat (`ADDR_ACCESS_CYCLES + 2) @(negedge ref_clk);
		res = dut_oe ? {1'b1, dut_q} : '0;
		{cs_n, oe_n, done} = 3'b111;
		@(negedge ref_clk);
		done = 1'b0;
		repeat (5) @(negedge ref_clk);
	endtask : rd
endmodule : host_model

// File: host_port_chk.sv
// Assertions on the host port pins.
// Assumes it is bound into the port module and sees its ports only.
`timescale 1ns/1ps
module host_port_chk
	import host_port_pkg::*;
#(
	parameter int unsigned RESET_HOLD = 20
) (
	input wire logic ref_clk,
	input wire logic rst_b,
	input wire logic chip_sel_n,
	input wire logic out_en_n,
	input wire logic write_en_n,
	input wire logic below_trip_in,
	input wire logic sram_enable_in_n,
	input wire logic sram_enable_out_n,
	input wire logic data_bus_pins_oe,
	input wire logic key_start_in_n,
	input wire logic supply_on_n,
	input wire logic reset_out_n
);
	// Counts cycles since reset and supply were both released.
	logic [31:0] up_q, up_d;
	always_comb up_d = (below_trip_in || !rst_b) ? 32'h0 : up_q + 32'h1;
	always_ff @(posedge ref_clk) up_q <= up_d;

	default clocking cb @(posedge ref_clk); endclocking
	default disable iff (!rst_b);

	fail_no_drive_a:
	assert property (below_trip_in [*5] |-> !data_bus_pins_oe) else $error("Data driven while failed");
	sram_forced_a:
	assert property (below_trip_in [*5] |-> sram_enable_out_n) else $error("SRAM enable not forced");
	sram_pass_a:
	assert property ((!below_trip_in && $stable(sram_enable_in_n)) [*5] |-> sram_enable_out_n == sram_enable_in_n)
		else $error("SRAM enable not passed");
	off_no_cs_a:
	assert property (chip_sel_n [*6] |-> !data_bus_pins_oe) else $error("Drive without select");
	off_no_oe_a:
	assert property (out_en_n [*6] |-> !data_bus_pins_oe) else $error("Drive without output enable");
	write_off_a:
	assert property ((!chip_sel_n && !write_en_n) [*6] |-> !data_bus_pins_oe) else $error("Drive during write");
	read_drive_a:
	assert property ((!chip_sel_n && !out_en_n && write_en_n && reset_out_n && !below_trip_in) [*8]
		|-> data_bus_pins_oe) else $error("No drive in read");
	fail_reset_a:
	assert property (below_trip_in [*5] |-> !reset_out_n) else $error("Reset not held in fail");
	hold_time_a:
	assert property ($rose(reset_out_n) |-> up_q >= RESET_HOLD) else $error("Reset released early");
	refuse_rst_a:
	assert property (!reset_out_n [*5] |-> !data_bus_pins_oe) else $error("Drive during reset");
	key_power_a:
	assert property ($fell(key_start_in_n) |-> ##[2:10] !supply_on_n) else $error("Key gave no supply-on");
endmodule : host_port_chk

bind power_fail_gated_host_port host_port_chk #(.RESET_HOLD(RESET_HOLD)) u_chk (.ref_clk(ref_clk), .rst_b(rst_b),
	.chip_sel_n(chip_sel_n), .out_en_n(out_en_n), .write_en_n(write_en_n), .below_trip_in(below_trip_in),
	.sram_enable_in_n(sram_enable_in_n), .sram_enable_out_n(sram_enable_out_n), .data_bus_pins_oe(data_bus_pins_oe),
	.key_start_in_n(key_start_in_n), .supply_on_n(supply_on_n), .reset_out_n(reset_out_n));

// File: tb_top.sv
// Self-checking bench for the power-fail gated host port.
// Assumes the host model drives the bus; hold count shortened to 20.
`timescale 1ns/1ps
`include "host_port_consts.svh"
module tb_top;
	import host_port_pkg::*;
	localparam int unsigned HOLD = 20;
	logic ref_clk = 1'b0, rst_b = 1'b0, below = 1'b0, sram_in_n = 1'b1, key_n = 1'b1, alarm = 1'b0, wdog = 1'b0;
	logic cs_n, oe_n, we_n, drv, done, oe, sram_out_n, irq_n, rst_out_n, sup_n;
	logic [`ADDR_W-1:0] addr, a;
	logic [`DATA_W-1:0] wd, din, q, d;
	logic [`DATA_W:0]   res;
	logic [`DATA_W:0]   expq[$];
	int                 n_errors = 0, cmp_count = 0, cyc = 0, n;

	always #2.5 ref_clk = ~ref_clk;
	// Wire level: host drive, else device drive, else a changing pattern.
	assign din = drv ? wd : (oe ? q : (8'h5A ^ {`DATA_W{ref_clk}}));

	power_fail_gated_host_port #(.RESET_HOLD(HOLD), .TICK_DIV(8)) u_dut (.ref_clk(ref_clk), .rst_b(rst_b),
		.chip_sel_n(cs_n), .out_en_n(oe_n), .write_en_n(we_n), .reg_addr_in(addr), .data_bus_pins_in(din),
		.data_bus_pins_out(q), .data_bus_pins_oe(oe), .below_trip_in(below), .sram_enable_in_n(sram_in_n),
		.sram_enable_out_n(sram_out_n), .key_start_in_n(key_n), .alarm_match_in(alarm),
		.watchdog_timeout_in(wdog), .irq_out_n(irq_n), .reset_out_n(rst_out_n), .supply_on_n(sup_n));
	host_model u_host (.ref_clk(ref_clk), .cs_n(cs_n), .oe_n(oe_n), .we_n(we_n), .addr(addr), .wd(wd),
		.drv(drv), .dut_oe(oe), .dut_q(q), .done(done), .res(res));

	task automatic chk(input string nm, input logic [`DATA_W:0] e, input logic [`DATA_W:0] g);
		cmp_count++;
		if (g !== e)
		begin
			n_errors++;
			$display("Error %s expected %h seen %h", nm, e, g);
		end
	endtask : chk

	task automatic give_verdict;
		$display("Comparisons %0d errors %0d", cmp_count, n_errors);
		if (n_errors == 0 && cmp_count > 0)
			$display("All tests passed");
		else
			$display("Some tests failed");
		$finish;
	endtask : give_verdict

	// Counts cycles until the reset output lets go.
	task automatic wait_rel;
		n = 0;
		while (rst_out_n !== 1'b1 && n < 100)
		begin
			@(negedge ref_clk);
			n++;
		end
		chk("reset hold", 9'h001, {8'h00, n >= HOLD && n <= HOLD + 8});
	endtask : wait_rel

	// Each read result is compared with the oldest expectation.
	always @(posedge ref_clk)
	begin
		cyc++;
		if (done)
			chk("read", expq.pop_front(), res);
		if (cyc == 20000)
		begin
			n_errors++;
			give_verdict();
		end
	end

	// Main sequence.
	initial
	begin
		void'($urandom(32'h6D138DFD));
		repeat (6) @(negedge ref_clk);
		rst_b = 1'b1;
		wait_rel();
		chk("irq idle", 9'h001, {8'h00, irq_n});
		expq.push_back(9'h180);
		u_host.rd(5'h0F);
		for (int i = 0; i < 4; i++)
		begin
			a = {1'b1, i[2:0], 1'b0};
			d = $urandom;
			u_host.wr(a, d, 1'b0);
			u_host.wr(a + 5'h01, ~d, i[0]);
			expq.push_back({1'b1, d});
			u_host.rd(a);
			expq.push_back({1'b1, ~d});
			u_host.rd(a + 5'h01);
		end
		below = 1'b1;
		sram_in_n = 1'b0;
		repeat (8) @(negedge ref_clk);
		chk("sram forced", 9'h001, {8'h00, sram_out_n});
		// A refused write to the last location written must leave its old byte in place.
		u_host.wr(5'h17, d, 1'b0);
		expq.push_back(9'h000);
		u_host.rd(5'h16);
		below = 1'b0;
		wait_rel();
		chk("sram pass", 9'h000, {8'h00, sram_out_n});
		expq.push_back({1'b1, ~d});
		u_host.rd(5'h17);
		// A watchdog event pulls the reset pin low while it lasts; then key and alarm raise flags.
		wdog = 1'b1;
		repeat (10) @(negedge ref_clk);
		chk("event reset", 9'h000, {8'h00, rst_out_n});
		{key_n, alarm, wdog} = 3'b010;
		repeat (10) @(negedge ref_clk);
		{key_n, alarm} = 2'b10;
		chk("supply on", 9'h000, {8'h00, sup_n});
		chk("irq event", 9'h000, {8'h00, irq_n});
		repeat (6) @(negedge ref_clk);
		chk("event release", 9'h001, {8'h00, rst_out_n});
		give_verdict();
	end
endmodule : tb_top
